// file: cmwp_pkg.sv
// Package for the bus mode and wake pattern controller.
// Assumes a single 25 MHz system clock; register port is plain strobes.
package cmwp_pkg;

  localparam int CLK_HZ = 25_000_000;
  // Wake pattern phase times in ns and the pattern timeout in us
  localparam int T_DOM_NS = 5000;
  localparam int T_REC_NS = 5000;
  localparam int T_TO_US = 1000;
  localparam int DOM_CYC = (T_DOM_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int REC_CYC = (T_REC_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int TO_CYC = T_TO_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W = 16;

  // Register offsets
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_MODE = 4'h1;
  localparam logic [3:0] A_STAT = 4'h2;
  localparam logic [3:0] A_MASK = 4'h3;
  localparam logic [3:0] A_FLT = 4'h4;

  // Control register bit positions
  localparam int C_LPL = 0;
  localparam int C_BSRC = 1;
  localparam int C_CWE = 2;
  localparam int C_SWE = 3;
  localparam int C_FMT = 4;
  localparam int C_TXEN = 5;
  localparam int C_FCV = 6;
  localparam int C_SWERR = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] FLT_RST = 8'h00;

  // Status bits: 0 bus wake event, 1 pattern seen
  localparam int S_WAKE = 0;
  localparam int S_PAT = 1;

  // Mode request codes
  localparam logic [2:0] REQ_OFF = 3'h0;
  localparam logic [2:0] REQ_PARK = 3'h1;
  localparam logic [2:0] REQ_LISTEN = 3'h2;
  localparam logic [2:0] REQ_ACTIVE = 3'h3;

  typedef enum logic [4:0] {
    M_OFF = 5'b00001,
    M_PARK = 5'b00010,
    M_BIAS = 5'b00100,
    M_LISTEN = 5'b01000,
    M_ACTIVE = 5'b10000
  } cmwp_mode_t;

  typedef enum logic [5:0] {
    P_IDLE = 6'b000001,
    P_DOM1 = 6'b000010,
    P_REC1 = 6'b000100,
    P_DOM2 = 6'b001000,
    P_REC2 = 6'b010000,
    P_DONE = 6'b100000
  } cmwp_pat_t;

  // Bias outputs
  localparam logic [1:0] B_HIZ = 2'h0;
  localparam logic [1:0] B_GND = 2'h1;
  localparam logic [1:0] B_BAT = 2'h2;
  localparam logic [1:0] B_VCC2 = 2'h3;

endpackage

// file: cmwp_ctrl.sv
// Bus mode machine with remote wake pattern detection.
// Assumes BUS_DOM is asynchronous to CLK_SYS; SYS_OFF comes from same clock.
//
// Functional notes
// R1: Off mode: transmitter, receiver off, bus floating
// R2: Parked: all off, ground bias, pattern wakes
// R3: Biased parked: bias on, pattern or frame
// R4: Listen: receiver only, transmitter recessive
// R5: Active: both on, half supply bias
// R6: Low-power listen: transmitter off, battery bias
// R7: Bias source picks battery or half supply
// R8: System off overrides every other transition
// R9: Pattern in parked enters biased parked
// R10: Wake event only under enable conditions
// R11: Format bit picks standard or extended
// R12: Dominant, recessive, dominant minimum phases
// R13: Extended adds final recessive phase
// R14: Short glitches neither finish nor break
// R15: Pattern must finish within timeout
// R16: Frame detection needs bias and enables
// R17: Filter config change clears valid bit
// R18: Phase times are cycle count constants
// R19: Wake sets sticky flag, pulses request
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cmwp_ctrl
  import cmwp_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic SYS_OFF,
  input wire logic [2:0] MODE_REQ,
  input wire logic MODE_REQ_VLD,
  input wire logic BUS_DOM,
  input wire logic TXD,
  input wire logic TXEN_PIN,
  output logic TX_EN,
  output logic TX_DOM,
  output logic RX_EN,
  output logic RXD_OUT,
  output logic [1:0] BIAS,
  output logic SWF_EN,
  output logic WAKE_REQ,
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////
  // Bus input synchroniser
  // The bus line is sampled three times; a level is accepted only when the
  // second and third stages agree, so a one-cycle spike never reaches the
  // pattern detector. The price is about four cycles of latency, small
  // against the minimum phase times.
  logic s1_q, s2_q, s3_q, dom_q;

  // Sampling stages
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= BUS_DOM;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accepted bus level
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      dom_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      dom_q <= s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  // Writes land at the edge that samples the strobe; reads answer one
  // cycle later. Unmapped indices read zero and ignore writes, so software
  // probing the map cannot disturb the mode machine.
  logic [7:0] ctrl_q, ctrl_d, flt_q, stat_q, stat_d, mask_q;
  cmwp_mode_t mode_q, mode_d;
  logic wake_ev, pat_ev;

  wire wr_ctrl = WR && (ADDR == A_CTRL);
  wire wr_flt = WR && (ADDR == A_FLT);
  wire wr_stat = WR && (ADDR == A_STAT);
  wire wr_mask = WR && (ADDR == A_MASK);

  // A filter write drops the valid bit so stale settings are never used;
  // software must set it again once the new filter is complete.
  // R17 auto clear valid
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) ctrl_d = WDATA;
    if (wr_flt && !(wr_ctrl && WDATA[C_FCV])) ctrl_d[C_FCV] = 1'b0;
  end

  // An event in the cycle of its clear keeps the bit set, so a wake that
  // races a software acknowledge is never lost.
  // R19 sticky, set wins
  wire [7:0] ev_set = {6'h00, pat_ev, wake_ev};
  always_comb begin
    stat_d = stat_q;
    if (wr_stat) stat_d = stat_q & ~WDATA;
    stat_d = stat_d | ev_set;
  end

  wire [7:0] rd_mux = (ADDR == A_CTRL) ? ctrl_q :
                      (ADDR == A_MODE) ? {3'h0, mode_q} :
                      (ADDR == A_STAT) ? stat_q :
                      (ADDR == A_MASK) ? mask_q :
                      (ADDR == A_FLT) ? flt_q : 8'h00;

  // Control register
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_q <= CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Filter configuration register
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      flt_q <= FLT_RST;
    end else if (wr_flt) begin
      flt_q <= WDATA;
    end
  end

  // Status register
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      stat_q <= 8'h00;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Interrupt mask register
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      mask_q <= 8'h00;
    end else if (wr_mask) begin
      mask_q <= WDATA;
    end
  end

  // Read data stands for each cycle after one with RD high, then returns to zero
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= RD ? rd_mux : 8'h00;
    end
  end

  // Level interrupt; stays high until every unmasked bit is cleared
  assign IRQ = |(stat_q & mask_q);

  ////////////////////////////////////////////////////////////////////////
  // Bus mode machine
  // One transition per cycle. System off beats any request, and a request
  // beats a pattern seen in the same cycle. A park request while biased
  // keeps the bias, so a node that already heard traffic does not drop
  // its bias and miss the frame that follows. New modes show at the
  // outputs one cycle after the request is taken.
  wire low_power_listen_sel = ctrl_q[C_LPL];
  wire bsrc = ctrl_q[C_BSRC];
  wire bus_wake_enable = ctrl_q[C_CWE];
  wire swe_on = ctrl_q[C_SWE] && ctrl_q[C_FCV];
  wire parked = (mode_q == M_PARK) || (mode_q == M_BIAS);

  always_comb begin
    mode_d = mode_q;
    // R8 off has priority
    if (SYS_OFF) begin
      mode_d = M_OFF;
    end else if (MODE_REQ_VLD) begin
      unique case (MODE_REQ)
        REQ_OFF: mode_d = M_OFF;
        REQ_PARK: mode_d = (mode_q == M_BIAS) ? M_BIAS : M_PARK;
        REQ_LISTEN: mode_d = M_LISTEN;
        default: mode_d = M_ACTIVE;
      endcase
    // R9 pattern turns bias on
    end else if (pat_ev && mode_q == M_PARK) begin
      mode_d = M_BIAS;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) mode_q <= M_OFF;
    else mode_q <= mode_d;
  end

  // R1 R2 R3 R4 R5 R6 mode outputs
  assign RX_EN = (mode_q == M_LISTEN) || (mode_q == M_ACTIVE);
  assign TX_EN = (mode_q == M_ACTIVE) || (mode_q == M_LISTEN && !low_power_listen_sel);
  // R5 transmit enable gate
  assign TX_DOM = (mode_q == M_ACTIVE) && !(ctrl_q[C_TXEN] && TXEN_PIN) && !TXD;
  // Receive output idles recessive while the receiver is off, so the
  // controller never sees a false start of frame on a mode change.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) RXD_OUT <= 1'b1;
    else RXD_OUT <= RX_EN ? !dom_q : 1'b1;
  end

  // Battery bias lets the bus stay biased without the transceiver supply;
  // the half-supply choice matches active levels but needs that supply.
  // Full active mode always uses half supply.
  // R7 bias source
  always_comb begin
    unique case (mode_q)
      M_OFF: BIAS = B_HIZ;
      M_PARK: BIAS = B_GND;
      M_BIAS: BIAS = bsrc ? B_VCC2 : B_BAT;
      M_LISTEN: BIAS = (low_power_listen_sel && !bsrc) ? B_BAT : B_VCC2;
      default: BIAS = B_VCC2;
    endcase
  end

  // Frame detection needs a biased bus; an error flag blocks it until
  // software has dealt with the cause.
  // R16 frame detection enable
  assign SWF_EN = (mode_q != M_OFF) && (mode_q != M_PARK) && bus_wake_enable && swe_on && !ctrl_q[C_SWERR];

  ////////////////////////////////////////////////////////////////////////
  // Wake pattern detector
  // The detector runs only while parked. Each phase counts cycles of the
  // wanted bus level; a shorter spell of the other level only pauses the
  // count, it neither completes nor breaks the phase. The timeout counts
  // from the first dominant cycle and returns the detector to idle, after
  // which the remote node must send the whole pattern again.
  // Limitation: phase counts accumulate across pauses, so a broken-up
  // dominant stretch whose parts add up to the minimum still qualifies.
  // After a complete pattern the detector waits for a recessive bus or the
  // timeout before it can start over, so one long dominant that ends before the timeout is not counted twice.
  cmwp_pat_t pat_q, pat_d;
  logic [CNT_W-1:0] ph_q, ph_d, to_q, to_d;

  // R18 cycle count thresholds
  function automatic logic met(input logic d, input logic [CNT_W-1:0] c);
    met = d ? (c >= CNT_W'(DOM_CYC - 1)) : (c >= CNT_W'(REC_CYC - 1));
  endfunction

  wire want_dom = (pat_q == P_DOM1) || (pat_q == P_DOM2);
  wire on_phase = (pat_q != P_IDLE) && (pat_q != P_DONE) && (dom_q == want_dom);
  wire ph_met = on_phase && met(dom_q, ph_q);
  wire timeout = (pat_q != P_IDLE) && (to_q >= CNT_W'(TO_CYC - 1));

  always_comb begin
    pat_d = pat_q;
    ph_d = on_phase ? ph_q + 1'b1 : ph_q;
    to_d = (pat_q == P_IDLE) ? '0 : to_q + 1'b1;
    pat_ev = 1'b0;
    // R15 timeout restarts
    if (!parked || timeout) begin
      pat_d = P_IDLE;
      ph_d = '0;
    end else begin
      unique case (pat_q)
        P_IDLE: if (dom_q) begin
          pat_d = P_DOM1;
          ph_d = CNT_W'(1);
        end
        // R12 R14 phase sequence
        P_DOM1: if (ph_met) begin
          pat_d = P_REC1;
          ph_d = '0;
        end
        P_REC1: if (ph_met) begin
          pat_d = P_DOM2;
          ph_d = '0;
        end
        P_DOM2: if (ph_met) begin
          // R11 R13 format choice
          pat_d = ctrl_q[C_FMT] ? P_REC2 : P_DONE;
          ph_d = '0;
          pat_ev = !ctrl_q[C_FMT];
        end
        P_REC2: if (ph_met) begin
          pat_d = P_DONE;
          pat_ev = 1'b1;
        end
        default: if (!dom_q) pat_d = P_IDLE;
      endcase
    end
    if (pat_d == P_IDLE) to_d = '0;
  end

  // R10 wake event gating
  assign wake_ev = pat_ev && parked && bus_wake_enable && !swe_on;

  // Detector state
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pat_q <= P_IDLE;
    end else begin
      pat_q <= pat_d;
    end
  end

  // Phase counter
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ph_q <= '0;
    end else begin
      ph_q <= ph_d;
    end
  end

  // Pattern timeout counter
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      to_q <= '0;
    end else begin
      to_q <= to_d;
    end
  end

  // R19 one cycle request
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      WAKE_REQ <= 1'b0;
    end else begin
      WAKE_REQ <= wake_ev;
    end
  end

endmodule
`default_nettype wire

// file: cmwp_ctrl_sva.sv
// Checker for the bus mode and wake pattern controller.
// Sees only the top ports; bound into every controller.
`timescale 1ns/1ps
`default_nettype none
module cmwp_ctrl_sva
  import cmwp_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic SYS_OFF,
  input wire logic TXD,
  input wire logic TX_EN,
  input wire logic TX_DOM,
  input wire logic RX_EN,
  input wire logic RXD_OUT,
  input wire logic [1:0] BIAS,
  input wire logic SWF_EN,
  input wire logic WAKE_REQ
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  sequence s_off;
    SYS_OFF;
  endsequence
  sequence s_wake;
    WAKE_REQ ##1 !WAKE_REQ;
  endsequence
  ////////////////////////////////////////////////////////////
  AST_OFF_WINS: assert property (s_off |=> !TX_EN && !RX_EN && BIAS == B_HIZ)
    else $error("off request not obeyed");
  AST_OFF_QUIET: assert property (BIAS == B_HIZ |-> !TX_EN && !RX_EN && !SWF_EN)
    else $error("floating bus with blocks on");
  AST_DOM_CAUSE: assert property (TX_DOM |-> TX_EN && RX_EN && !TXD)
    else $error("dominant drive without cause");
  AST_TX_BIAS: assert property (TX_EN |-> RX_EN && BIAS == B_VCC2)
    else $error("transmitter on with wrong bias");
  AST_RX_IDLE: assert property (!RX_EN ##1 !RX_EN |-> RXD_OUT)
    else $error("receive output moved while off");
  AST_WAKE_PULSE: assert property (WAKE_REQ |-> s_wake)
    else $error("wake request longer than one cycle");
  AST_WAKE_BIAS: assert property (WAKE_REQ && !SYS_OFF |-> ##[0:2] BIAS[1])
    else $error("wake without bus bias");
  AST_SWF_BIAS: assert property (SWF_EN |-> BIAS == B_BAT || BIAS == B_VCC2)
    else $error("frame detection without bias");
endmodule
bind cmwp_ctrl cmwp_ctrl_sva u_sva (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .SYS_OFF(SYS_OFF),
  .TXD(TXD), .TX_EN(TX_EN), .TX_DOM(TX_DOM), .RX_EN(RX_EN), .RXD_OUT(RXD_OUT),
  .BIAS(BIAS), .SWF_EN(SWF_EN), .WAKE_REQ(WAKE_REQ));
`default_nettype wire

// file: cmwp_node.sv
// Remote bus node sending one wake pattern per go pulse.
// Termination keeps the idle bus recessive, so low is safe.
`timescale 1ns/1ps
`default_nettype none
module cmwp_node (
  input wire logic clk,
  input wire logic go,
  input wire logic [15:0] len,
  output var logic dom
);
  initial dom = 1'b0;
  always @(posedge go) begin
    @(posedge clk);
    dom <= 1'b1;
    repeat (60) @(posedge clk);
    dom <= 1'b0;
    repeat (2) @(posedge clk);
    dom <= 1'b1;
    repeat (len - 60) @(posedge clk);
    dom <= 1'b0;
    repeat (len) @(posedge clk);
    dom <= 1'b1;
    repeat (len) @(posedge clk);
    dom <= 1'b0;
  end
endmodule
`default_nettype wire

// file: cmwp_ctrl_tb.sv
// Bench for the bus mode and wake pattern controller.
// One clock; a remote node model drives the bus line.
`timescale 1ns/1ps
`default_nettype none
module cmwp_ctrl_tb
  import cmwp_pkg::*;
;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, off = 0, vld = 0;
  logic txd = 1, txp = 0, go = 0, dom, wk = 0;
  logic tx_en, tx_dom, rx_en, rxd, swf, wake, irq;
  logic [3:0] adr = 4'h0;
  logic [7:0] wd = 8'h00, rdat;
  logic [2:0] req = 3'h0;
  logic [1:0] bias;
  logic [15:0] len = 16'h0000;
  int num_errors = 0, tests_run = 0, cyc = 0;
  always #20 clk = ~clk;
  cmwp_ctrl DUT (.CLK_SYS(clk), .RESETN(rstn), .ADDR(adr), .WDATA(wd), .WR(wr), .RD(rd),
    .RDATA(rdat), .SYS_OFF(off), .MODE_REQ(req), .MODE_REQ_VLD(vld), .BUS_DOM(dom),
    .TXD(txd), .TXEN_PIN(txp), .TX_EN(tx_en), .TX_DOM(tx_dom), .RX_EN(rx_en),
    .RXD_OUT(rxd), .BIAS(bias), .SWF_EN(swf), .WAKE_REQ(wake), .IRQ(irq));
  cmwp_node u_node (.clk(clk), .go(go), .len(len), .dom(dom));
  ////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrr(input logic [3:0] a, input logic [7:0] d);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] e);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(nm, rdat, e);
    @(posedge clk);
  endtask
  task automatic mode(input logic [2:0] m);
    req <= m;
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [7:0] e(input logic [2:0] t, input logic [1:0] b);
    return {3'h0, t, b};
  endfunction
  task automatic outs(input string nm, input logic [7:0] x);
    @(negedge clk);
    chk(nm, {3'h0, tx_en, rx_en, tx_dom, bias}, {3'h0, x[4:0]});
    chk("irq", {7'h0, irq}, {7'h0, x[7]});
    @(posedge clk);
  endtask
  task automatic pat(input logic [15:0] l, input int w);
    wk <= 1'b0;
    len <= l;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (w) @(posedge clk);
  endtask
  // Hang guard: the longest pattern wait is 27300 cycles
  always @(posedge clk) begin
    cyc++;
    if (wake) wk <= 1'b1;
    if (cyc == 40000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdc("mode", A_MODE, 8'h01);
    outs("off", e(3'h0, B_HIZ));
    wrr(A_CTRL, 8'h04);
    mode(REQ_PARK);
    outs("park", e(3'h0, B_GND));
    mode(REQ_LISTEN);
    outs("listen", e(3'h6, B_VCC2));
    pat(16'd135, 20);
    chk("rxd", {7'h0, rxd}, 8'h00);
    repeat (700) @(posedge clk);
    chk("wake", {7'h0, wk}, 8'h00);
    wrr(A_CTRL, 8'h05);
    outs("lpl", e(3'h2, B_BAT));
    $display("test modes done");
    mode(REQ_ACTIVE);
    txd <= 1'b0;
    outs("active", e(3'h7, B_VCC2));
    wrr(A_CTRL, 8'h25);
    txp <= 1'b1;
    outs("gated", e(3'h6, B_VCC2));
    txd <= 1'b1;
    txp <= 1'b0;
    req <= REQ_ACTIVE;
    vld <= 1'b1;
    off <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    off <= 1'b0;
    @(posedge clk);
    rdc("mode", A_MODE, 8'h01);
    $display("test active done");
    wrr(A_MASK, 8'h01);
    wrr(A_CTRL, 8'h04);
    mode(REQ_PARK);
    pat(16'd135, 700);
    chk("wake", {7'h0, wk}, 8'h01);
    rdc("mode", A_MODE, 8'h04);
    outs("biased", 8'h82);
    rdc("stat", A_STAT, 8'h03);
    wrr(A_STAT, 8'h03);
    outs("clear", e(3'h0, B_BAT));
    wrr(A_CTRL, 8'h4e);
    outs("vcc", e(3'h0, B_VCC2));
    chk("swf", {7'h0, swf}, 8'h01);
    pat(16'd135, 700);
    chk("wake", {7'h0, wk}, 8'h00);
    $display("test wake done");
    wrr(A_CTRL, 8'h14);
    mode(REQ_OFF);
    mode(REQ_PARK);
    pat(16'd135, 465);
    chk("ext", {7'h0, wk}, 8'h00);
    repeat (200) @(posedge clk);
    chk("ext", {7'h0, wk}, 8'h01);
    wrr(A_CTRL, 8'h04);
    mode(REQ_OFF);
    mode(REQ_PARK);
    pat(16'd100, 600);
    chk("short", {7'h0, wk}, 8'h00);
    mode(REQ_OFF);
    mode(REQ_PARK);
    pat(16'd12600, 27300);
    chk("late", {7'h0, wk}, 8'h00);
    $display("test pattern done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
